// ---- common/irq_event_pkg.sv ----
`default_nettype none
package irq_event_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned NUM_PINS  = 8;
   localparam int unsigned NUM_DEST  = 15;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned SYNC_LEN  = 2;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_PRIO_LOW   = 8'h00;
   localparam logic [7:0] OFS_PRIO_HIGH  = 8'h04;
   localparam logic [7:0] OFS_RISE_EN    = 8'h08;
   localparam logic [7:0] OFS_FALL_EN    = 8'h0C;
   localparam logic [7:0] OFS_ROUTE_00   = 8'h10;
   localparam logic [7:0] OFS_ROUTE_16   = 8'h14;
   localparam logic [7:0] OFS_REQ_FLAGS  = 8'h18;
   localparam logic [7:0] OFS_REQ_MASK   = 8'h1C;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_PRIO       = 8'hFF;
   localparam logic [7:0] RST_EDGE_EN    = 8'h00;
   localparam logic [3:0] RST_ROUTE      = 4'h0;
   localparam logic [7:0] RST_FLAGS      = 8'h00;
   localparam logic [7:0] RST_MASK       = 8'h00;

   // ---------------------------------------------------------------
   // link codes, bus answers and lowest level
   // ---------------------------------------------------------------
   localparam logic [3:0] CODE_OFF       = 4'h0;
   localparam logic [3:0] CODE_ADC       = 4'h1;
   localparam logic [3:0] CODE_TIMER0    = 4'h2;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;
   localparam logic [1:0] LVL_LOWEST     = 2'h3;

endpackage
`default_nettype wire

// ---- rtl/ext_irq_edge_event_link.sv ----
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01 - priority bits: high in second, low first
// R02 - code 00 highest, 11 lowest priority
// R03 - rise and fall enables, bit n pin n
// R04 - enables 00 off, 01 fall, 10 rise, 11 both
// R05 - select register: 4-bit code, upper bits unused
// R06 - code zero disables, nonzero forwards event
// R07 - generator 0 routes pin 0 edge
// R08 - valid edge sets request flag
// R09 - code 0010 timer input, 0001 converter start
// R10 - synchronised pin, one-cycle event, same cycle
module ext_irq_edge_event_link
   import irq_event_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // external interrupt pins and generator 16 event
   input  wire logic [NUM_PINS-1:0] ext_irq_pin,
   input  wire logic                timer0_count_end,
   // destination trigger pulses, bit k-1 for link code k
   output logic      [NUM_DEST-1:0] dest_trigger,
   // interrupt to the core
   output logic                     irq,
   output logic      [1:0]          irq_level,
   output logic      [2:0]          irq_pin,
   // axi4-lite write address
   input  wire logic                s_axil_awvalid,
   output logic                     s_axil_awready,
   input  wire logic [ADDR_W-1:0]   s_axil_awaddr,
   input  wire logic [2:0]          s_axil_awprot,
   // axi4-lite write data
   input  wire logic                s_axil_wvalid,
   output logic                     s_axil_wready,
   input  wire logic [31:0]         s_axil_wdata,
   input  wire logic [3:0]          s_axil_wstrb,
   // axi4-lite write response
   output logic                     s_axil_bvalid,
   input  wire logic                s_axil_bready,
   output logic      [1:0]          s_axil_bresp,
   // axi4-lite read address
   input  wire logic                s_axil_arvalid,
   output logic                     s_axil_arready,
   input  wire logic [ADDR_W-1:0]   s_axil_araddr,
   input  wire logic [2:0]          s_axil_arprot,
   // axi4-lite read data
   output logic                     s_axil_rvalid,
   input  wire logic                s_axil_rready,
   output logic      [31:0]         s_axil_rdata,
   output logic      [1:0]          s_axil_rresp
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]          prio_lo;
      logic [7:0]          prio_hi;
      logic [7:0]          rise_en;
      logic [7:0]          fall_en;
      logic [3:0]          route00;
      logic [3:0]          route16;
      logic [7:0]          flag;
      logic [7:0]          mask;
      logic                awready;
      logic                aw_got;
      logic [ADDR_W-1:0]   awaddr;
      logic                wready;
      logic                w_got;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic [NUM_DEST-1:0] dest;
      logic                irq;
      logic [1:0]          lvl;
      logic [2:0]          pin;
   } state_t;

   localparam state_t ST_RESET = '{
      prio_lo : RST_PRIO,
      prio_hi : RST_PRIO,
      rise_en : RST_EDGE_EN,
      fall_en : RST_EDGE_EN,
      route00 : RST_ROUTE,
      route16 : RST_ROUTE,
      flag    : RST_FLAGS,
      mask    : RST_MASK,
      awready : 1'b1,
      wready  : 1'b1,
      arready : 1'b1,
      default : '0
   };

   state_t              st_q;
   state_t              st_d;
   logic [NUM_PINS-1:0] edge_w;
   logic [NUM_PINS-1:0] pend;
   logic [1:0]          best_lvl;
   logic [2:0]          best_pin;
   logic                found;
   logic [7:0]          wbyte;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [1:0] prio_level(input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic [2:0] idx);
      return {hi[idx], lo[idx]}; // R01
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_PRIO_LOW, OFS_PRIO_HIGH, OFS_RISE_EN, OFS_FALL_EN,
         OFS_ROUTE_00, OFS_ROUTE_16, OFS_REQ_FLAGS, OFS_REQ_MASK:
            return 1'b1;
         default:
            return 1'b0;
      endcase
   endfunction

   // a zero code never selects a destination
   function automatic logic [NUM_DEST-1:0] route_pulse(input logic [3:0] code,
                                                       input logic       ev);
      logic [NUM_DEST-1:0] r;
      r = '0;
      if (ev && code != CODE_OFF) begin // R06
         r[code - 4'h1] = 1'b1;         // R09
      end
      return r;
   endfunction

   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                             input state_t            s);
      case (a)
         OFS_PRIO_LOW:  return {24'h000000, s.prio_lo};
         OFS_PRIO_HIGH: return {24'h000000, s.prio_hi};
         OFS_RISE_EN:   return {24'h000000, s.rise_en};
         OFS_FALL_EN:   return {24'h000000, s.fall_en};
         OFS_ROUTE_00:  return {28'h0000000, s.route00}; // R05
         OFS_ROUTE_16:  return {28'h0000000, s.route16}; // R05
         OFS_REQ_FLAGS: return {24'h000000, s.flag};
         OFS_REQ_MASK:  return {24'h000000, s.mask};
         default:       return 32'h00000000;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // pin edge detectors
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      pin_edge_detect u_det (
         .clk        (clk),
         .rst_n      (rst_n),
         .pin        (ext_irq_pin[g]),
         .rise_en    (st_q.rise_en[g]), // R03
         .fall_en    (st_q.fall_en[g]), // R03
         .edge_pulse (edge_w[g])
      );
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      pend     = '0;
      best_lvl = LVL_LOWEST;
      best_pin = 3'h0;
      found    = 1'b0;
      wbyte    = st_q.wdata[7:0];

      // routing pulses leave in the same cycle the flag is raised
      st_d.dest = route_pulse(st_q.route00, edge_w[0])          // R07 R10
                | route_pulse(st_q.route16, timer0_count_end);

      // write channels are taken independently, in either order
      if (s_axil_awvalid && st_q.awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axil_awaddr;
      end
      if (s_axil_wvalid && st_q.wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axil_wdata;
         st_d.wstrb = s_axil_wstrb;
      end
      if (st_q.bvalid && s_axil_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = is_mapped(st_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
         // only byte lane 0 carries register bits
         if (st_q.wstrb[0]) begin
            case (st_q.awaddr)
               OFS_PRIO_LOW:  st_d.prio_lo = wbyte;
               OFS_PRIO_HIGH: st_d.prio_hi = wbyte;
               OFS_RISE_EN:   st_d.rise_en = wbyte;       // R03
               OFS_FALL_EN:   st_d.fall_en = wbyte;       // R03
               OFS_ROUTE_00:  st_d.route00 = wbyte[3:0];  // R05
               OFS_ROUTE_16:  st_d.route16 = wbyte[3:0];  // R05
               OFS_REQ_FLAGS: st_d.flag    = st_q.flag & ~wbyte;
               OFS_REQ_MASK:  st_d.mask    = wbyte;
               default:       st_d.flag    = st_q.flag;
            endcase
         end
      end
      // a new edge beats a write-one-to-clear in the same cycle
      st_d.flag    = st_d.flag | edge_w; // R08
      st_d.awready = !st_d.aw_got;
      st_d.wready  = !st_d.w_got;

      // read: answer registered on the edge that takes the address
      if (s_axil_arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = read_word(s_axil_araddr, st_q);
         st_d.rresp  = is_mapped(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (st_q.rvalid && s_axil_rready) begin
         st_d.rvalid = 1'b0;
      end
      st_d.arready = !st_d.rvalid;

      // interrupt: lowest level number wins, ties to the lower pin
      pend     = st_d.flag & st_d.mask;
      st_d.irq = |pend;
      for (int i = NUM_PINS - 1; i >= 0; i--) begin
         if (pend[i] && (!found ||
             prio_level(st_d.prio_hi, st_d.prio_lo, 3'(i)) <= best_lvl))
         begin // R02
            found    = 1'b1;
            best_lvl = prio_level(st_d.prio_hi, st_d.prio_lo, 3'(i));
            best_pin = 3'(i);
         end
      end
      st_d.lvl = best_lvl;
      st_d.pin = best_pin;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign dest_trigger   = st_q.dest;
   assign irq            = st_q.irq;
   assign irq_level      = st_q.lvl;
   assign irq_pin        = st_q.pin;
   assign s_axil_awready = st_q.awready;
   assign s_axil_wready  = st_q.wready;
   assign s_axil_bvalid  = st_q.bvalid;
   assign s_axil_bresp   = st_q.bresp;
   assign s_axil_arready = st_q.arready;
   assign s_axil_rvalid  = st_q.rvalid;
   assign s_axil_rdata   = st_q.rdata;
   assign s_axil_rresp   = st_q.rresp;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic has_lvl0;
   always_comb begin
      has_lvl0 = 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (st_q.flag[i] && st_q.mask[i] &&
             prio_level(st_q.prio_hi, st_q.prio_lo, 3'(i)) == 2'h0) begin
            has_lvl0 = 1'b1;
         end
      end
   end

   a_flag_set: // R08
   assert property (@(posedge clk) disable iff (!rst_n)
      (|edge_w) |=> ((st_q.flag & $past(edge_w)) == $past(edge_w)))
      else $error("edge did not raise its request flag");

   a_route_timer0: // R07
   assert property (@(posedge clk) disable iff (!rst_n)
      (edge_w[0] && st_q.route00 == CODE_TIMER0)
      |=> dest_trigger[1] && st_q.flag[0])
      else $error("pin 0 edge not routed to timer channel 0");

   a_route_adc: // R09
   assert property (@(posedge clk) disable iff (!rst_n)
      (edge_w[0] && st_q.route00 == CODE_ADC) |=> dest_trigger[0])
      else $error("pin 0 edge did not start the converter");

   a_route_off: // R06
   assert property (@(posedge clk) disable iff (!rst_n)
      (st_q.route00 == CODE_OFF && st_q.route16 == CODE_OFF)
      |=> dest_trigger == '0)
      else $error("event forwarded while link disabled");

   a_route_once: // R10
   assert property (@(posedge clk) disable iff (!rst_n)
      (dest_trigger != '0) |-> $past(edge_w[0] || timer0_count_end))
      else $error("trigger pulse without a source event");

   a_irq_level: // R01
   assert property (@(posedge clk) disable iff (!rst_n)
      irq |-> irq_level == prio_level(st_q.prio_hi, st_q.prio_lo, irq_pin))
      else $error("reported level does not match priority bits");

   a_prio_zero: // R02
   assert property (@(posedge clk) disable iff (!rst_n)
      has_lvl0 |-> irq && irq_level == 2'h0)
      else $error("level 0 request not chosen first");

   a_sel_width: // R05
   assert property (@(posedge clk) disable iff (!rst_n)
      (s_axil_arvalid && s_axil_arready && s_axil_araddr == OFS_ROUTE_00)
      |=> s_axil_rvalid && s_axil_rdata[31:4] == '0)
      else $error("select register upper bits not zero");

   // flags only fall in the cycle that performs a bus write
   a_flag_sticky: // R08
   assert property (@(posedge clk) disable iff (!rst_n)
      !(st_q.aw_got && st_q.w_got)
      |=> (st_q.flag & $past(st_q.flag)) == $past(st_q.flag))
      else $error("request flag dropped without a clear");

   a_lvl3_only: // R02
   assert property (@(posedge clk) disable iff (!rst_n)
      (irq && irq_level == LVL_LOWEST)
      |-> (st_q.flag & st_q.mask & ~(st_q.prio_hi & st_q.prio_lo)) == '0)
      else $error("lowest level chosen over a higher one");

   a_route16_adc: // R09
   assert property (@(posedge clk) disable iff (!rst_n)
      (timer0_count_end && st_q.route16 == CODE_ADC) |=> dest_trigger[0])
      else $error("generator 16 event did not start the converter");

   a_route16_timer: // R09
   assert property (@(posedge clk) disable iff (!rst_n)
      (timer0_count_end && st_q.route16 == CODE_TIMER0) |=> dest_trigger[1])
      else $error("generator 16 event not routed to timer channel 0");

endmodule // ext_irq_edge_event_link
`default_nettype wire

// ---- rtl/pin_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
   import irq_event_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin and edge selection
   input  wire logic pin,
   input  wire logic rise_en,
   input  wire logic fall_en,
   // one-cycle detected edge
   output logic      edge_pulse
);

   typedef struct packed {
      logic [SYNC_LEN-1:0] sync;
      logic                prev;
   } det_t;

   det_t det_q;
   det_t det_d;

   // ---------------------------------------------------------------
   // synchroniser: sync[0] is only read by sync[1]
   // ---------------------------------------------------------------
   always_comb begin
      det_d      = det_q;
      det_d.sync = {det_q.sync[SYNC_LEN-2:0], pin};
      det_d.prev = det_q.sync[SYNC_LEN-1];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         det_q <= '0;
      end else begin
         det_q <= det_d;
      end
   end

   always_comb begin
      edge_pulse = (rise_en &  det_q.sync[SYNC_LEN-1] & ~det_q.prev) // R04
                 | (fall_en & ~det_q.sync[SYNC_LEN-1] &  det_q.prev); // R04
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_rise_detect: // R04
   assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(pin) && rise_en) ##1 rise_en ##1 rise_en |-> edge_pulse)
      else $error("rising edge not detected");

   a_fall_detect: // R04
   assert property (@(posedge clk) disable iff (!rst_n)
      ($fell(pin) && fall_en) ##1 fall_en ##1 fall_en |-> edge_pulse)
      else $error("falling edge not detected");

   a_no_detect: // R04
   assert property (@(posedge clk) disable iff (!rst_n)
      (!rise_en && !fall_en) |-> !edge_pulse)
      else $error("edge reported while detection disabled");

   // the next pulse follows the pin one and two edges back, not the
   // present pin, so toggling every cycle must not trip this check
   a_one_pulse: // R10
   assert property (@(posedge clk) disable iff (!rst_n)
      edge_pulse && $past(pin) == $past(pin, 2) |=> !edge_pulse)
      else $error("edge pulse longer than one cycle");

endmodule // pin_edge_detect
`default_nettype wire

// ---- testbench/ext_irq_edge_event_link_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_irq_edge_event_link_tb
   import irq_event_pkg::*;
;
   logic        clk, rst_n, cnt_end, irq;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  pins, awaddr, araddr;
   logic [14:0] dest;
   logic [1:0]  lvl, bresp, rresp, resp;
   logic [2:0]  ipin, prot;
   logic [31:0] wdata, rdata, data;
   logic [3:0]  wstrb;
   int          n_errors = 0;
   int          total_checks = 0;

   pin_source src (.clk(clk), .pins(pins));

   ext_irq_edge_event_link uut (
      .clk(clk), .rst_n(rst_n), .ext_irq_pin(pins),
      .timer0_count_end(cnt_end), .dest_trigger(dest), .irq(irq),
      .irq_level(lvl), .irq_pin(ipin),
      .s_axil_awvalid(awvalid), .s_axil_awready(awready),
      .s_axil_awaddr(awaddr), .s_axil_awprot(prot),
      .s_axil_wvalid(wvalid), .s_axil_wready(wready),
      .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
      .s_axil_bvalid(bvalid), .s_axil_bready(bready),
      .s_axil_bresp(bresp), .s_axil_arvalid(arvalid),
      .s_axil_arready(arready), .s_axil_araddr(araddr),
      .s_axil_arprot(prot), .s_axil_rvalid(rvalid),
      .s_axil_rready(rready), .s_axil_rdata(rdata), .s_axil_rresp(rresp));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // reporting and comparisons
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic err(input string m);
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic chk_word(input logic [31:0] g, e, input string m);
      total_checks++;
      if (g !== e) err($sformatf("%s got %h want %h", m, g, e));
   endtask

   task automatic chk_resp(input logic [1:0] g, e, input string m);
      total_checks++;
      if (g !== e) err($sformatf("%s resp %h want %h", m, g, e));
   endtask

   task automatic chk_evt(input logic [14:0] g, e, input string m);
      total_checks++;
      if (g !== e) err($sformatf("%s out %h want %h", m, g, e));
   endtask

   function automatic logic [14:0] exp_trig(input logic [3:0] c);
      return (c == 4'h0) ? 15'h0000 : 15'h0001 << (c - 4'h1);
   endfunction

   // lowest level wins, ties go to the lowest pin
   function automatic logic [4:0] exp_pick(input logic [7:0] lo, hi, p);
      logic [1:0] best;
      logic [2:0] idx;
      best = 2'h3;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (p[i] && {hi[i], lo[i]} <= best) begin
            best = {hi[i], lo[i]};
            idx = 3'(i);
         end
      end
      return {best, idx};
   endfunction

   // ---------------------------------------------------------------
   // register bus master
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      prot <= 3'($urandom);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      r = bresp;
      if (!bvalid) begin
         err("no write response");
         stop_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      prot <= 3'($urandom);
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      d = rdata;
      r = rresp;
      if (!rvalid) begin
         err("no read data");
         stop_test();
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input string m);
      rd(a, data, resp);
      chk_word(data, e, m);
      chk_resp(resp, RESP_OKAY, m);
   endtask

   // counts cycles with any trigger; a pulse longer than one cycle
   // shows up as a count above one
   task automatic watch(input int n, output int cnt,
                        output logic [14:0] seen, output logic ia);
      cnt = 0;
      seen = 15'h0000;
      ia = 1'b0;
      repeat (n) begin
         @(posedge clk);
         if (dest !== 15'h0000) begin
            cnt++;
            seen |= dest;
            ia = irq;
         end
      end
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   task automatic test_regs();
      logic [7:0] adr [7] = '{OFS_PRIO_LOW, OFS_PRIO_HIGH, OFS_RISE_EN,
                              OFS_FALL_EN, OFS_ROUTE_00, OFS_ROUTE_16,
                              OFS_REQ_MASK};
      logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F,
                              8'hFF};
      logic [7:0] rst [7] = '{RST_PRIO, RST_PRIO, RST_EDGE_EN, RST_EDGE_EN,
                              {4'h0, RST_ROUTE}, {4'h0, RST_ROUTE},
                              RST_MASK};
      logic [31:0] v;
      for (int i = 0; i < 7; i++) rd_chk(adr[i], 32'(rst[i]), "reset");
      rd_chk(OFS_REQ_FLAGS, 32'(RST_FLAGS), "reset flags");
      for (int i = 0; i < 7; i++) begin
         v = $urandom;
         wr(adr[i], v, 4'hF, resp);
         chk_resp(resp, RESP_OKAY, "write");
         rd_chk(adr[i], 32'(v[7:0] & msk[i]), "readback");
         wr(adr[i], ~v, 4'hE, resp);
         rd_chk(adr[i], 32'(v[7:0] & msk[i]), "lane off");
      end
      rd(8'h20, data, resp);
      chk_word(data, 32'h0, "unmapped read");
      chk_resp(resp, RESP_SLVERR, "unmapped read");
      wr(8'h20, 32'hFF, 4'hF, resp);
      chk_resp(resp, RESP_SLVERR, "unmapped write");
      $display("test regs finished");
   endtask

   task automatic test_edges();
      int n;
      n = $urandom_range(7, 0);
      wr(OFS_REQ_MASK, 32'h0, 4'hF, resp);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_RISE_EN, 32'((m / 2) << n), 4'hF, resp);
         wr(OFS_FALL_EN, 32'((m % 2) << n), 4'hF, resp);
         wr(OFS_REQ_FLAGS, 32'hFF, 4'hF, resp);
         src.drive(8'(1 << n));
         repeat (6) @(posedge clk);
         chk_evt({14'h0, irq}, 15'h0, "masked irq");
         rd_chk(OFS_REQ_FLAGS, 32'((m / 2) << n), "rise");
         wr(OFS_REQ_FLAGS, 32'hFF, 4'hF, resp);
         src.drive(8'h00);
         repeat (6) @(posedge clk);
         rd_chk(OFS_REQ_FLAGS, 32'((m % 2) << n), "fall");
      end
      $display("test edges finished");
   endtask

   task automatic test_routes();
      int          cnt;
      logic [14:0] sn;
      logic        ia;
      logic [3:0]  c16;
      wr(OFS_REQ_MASK, 32'h01, 4'hF, resp);
      wr(OFS_RISE_EN, 32'h01, 4'hF, resp);
      wr(OFS_FALL_EN, 32'h00, 4'hF, resp);
      for (int c = 0; c < 16; c++) begin
         wr(OFS_ROUTE_00, 32'(c), 4'hF, resp);
         wr(OFS_REQ_FLAGS, 32'hFF, 4'hF, resp);
         src.drive(8'h01);
         watch(8, cnt, sn, ia);
         chk_evt(sn, exp_trig(4'(c)), "pin0 route");
         chk_word(32'(cnt), 32'(c != 0), "pulse count");
         if (c != 0) chk_word({31'h0, ia}, 32'h1, "irq with event");
         rd_chk(OFS_REQ_FLAGS, 32'h01, "flag set");
         src.drive(8'h00);
         watch(6, cnt, sn, ia);
         chk_word(32'(cnt), 32'h0, "fall ignored");
         c16 = 4'($urandom_range(15, 0));
         wr(OFS_ROUTE_16, 32'(c16), 4'hF, resp);
         cnt_end <= 1'b1;
         @(posedge clk);
         cnt_end <= 1'b0;
         watch(4, cnt, sn, ia);
         chk_evt(sn, exp_trig(c16), "gen16 route");
      end
      $display("test routes finished");
   endtask

   task automatic test_prio();
      logic [7:0] lo, hi, p;
      wr(OFS_RISE_EN, 32'hFF, 4'hF, resp);
      for (int it = 0; it < 8; it++) begin
         lo = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($urandom);
         hi = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($urandom);
         p = (it < 2) ? 8'hFF : 8'($urandom_range(255, 1));
         wr(OFS_PRIO_LOW, 32'(lo), 4'hF, resp);
         wr(OFS_PRIO_HIGH, 32'(hi), 4'hF, resp);
         wr(OFS_REQ_MASK, 32'hFF, 4'hF, resp);
         src.drive(p);
         repeat (6) @(posedge clk);
         chk_evt({9'h0, irq, lvl, ipin}, {9'h1, exp_pick(lo, hi, p)},
                 "priority");
         src.drive(8'h00);
         wr(OFS_REQ_MASK, 32'h00, 4'hF, resp);
         repeat (3) @(posedge clk);
         chk_evt({14'h0, irq}, 15'h0, "mask off");
         wr(OFS_REQ_MASK, 32'hFF, 4'hF, resp);
         wr(OFS_REQ_FLAGS, 32'hFF, 4'hF, resp);
         repeat (3) @(posedge clk);
         chk_evt({9'h0, irq, lvl, ipin}, {9'h0, LVL_LOWEST, 3'h0}, "clear");
         rd_chk(OFS_REQ_FLAGS, 32'h0, "flags cleared");
      end
      $display("test prio finished");
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err("watchdog expired");
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      cnt_end = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      prot = 3'h0;
      void'($urandom(2383));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      test_regs();
      test_edges();
      test_routes();
      test_prio();
      stop_test();
   end
endmodule // ext_irq_edge_event_link_tb
`default_nettype wire

// ---- testbench/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// external signal source on the interrupt pins
// ---------------------------------------------------------------
module pin_source (
   // clock
   input  wire logic       clk,
   // pins towards the block
   output var  logic [7:0] pins
);
   initial pins = 8'h00;

   // levels change just after an edge and stand until the next call;
   // callers hold them several cycles so the synchroniser sees them
   task automatic drive(input logic [7:0] v);
      @(posedge clk);
      pins <= v;
   endtask
endmodule // pin_source
`default_nettype wire
